// File: shared/timer_defs.svh
/*
 Offsets, field positions, reset values and clock-select codes of the
 8-bit up/down event timer. Assumes inclusion by bare name.
*/
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
// Register indices; byte address is four times the index
`define IDX_MODE_CTRL 24'hff_ffb4
`define IDX_COUNT_RELOAD 24'hff_ffb5
`define IDX_IRQ_EN_ONE 24'hff_fff3
`define IDX_IRQ_EN_TWO 24'hff_fff4
`define IDX_IRQ_REQ_TWO 24'hff_fff7
// Field positions
`define BIT_RELOAD_MODE 7
`define BIT_DIR_HI 6
`define BIT_DIR_LO 5
`define BIT_MODE_RSV 4
`define BIT_CLOCK_IRQ_EN 7
`define BIT_TIMER_IRQ_EN 1
`define BIT_TIMER_IRQ_FLAG 1
// Reset values
`define RST_MODE_CTRL 8'h10
`define RST_COUNT 8'h00
`define RST_RELOAD 8'h00
// Clock-select codes
`define CS_SYS_8192 4'b?000
`define CS_SYS_2048 4'b?001
`define CS_SYS_512 4'b?010
`define CS_SYS_64 4'b?011
`define CS_SYS_16 4'b?100
`define CS_SYS_4 4'b0101
`define CS_SUB_1024 4'b0110
`define CS_SUB_256 4'b1101
`define CS_SUB_4 4'b1110
`define CS_EVT_FALL 4'b0111
`define CS_EVT_RISE 4'b1111
// Divider exponents (log2 of the division)
`define LG_8192 4'd13
`define LG_2048 4'd11
`define LG_512 4'd9
`define LG_64 4'd6
`define LG_16 4'd4
`define LG_4 4'd2
`define LG_1024 4'd10
`define LG_256 4'd8
`endif

// File: shared/timer_pkg.sv
/*
 Types of the 8-bit up/down event timer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package timer_pkg;
    // Mode control register layout
    typedef struct packed {
        logic reload_mode_bit;
        logic direction_ctrl_hi;
        logic direction_ctrl_lo;
        logic reserved_one;
        logic [3:0] clock_select;
    } mode_ctrl_s;
endpackage : timer_pkg

// File: core/updown_event_timer_8bit.sv
/*
 8-bit up/down timer counter with selectable clock source, interval or
 auto-reload operation, request flag and two enable registers, on APB.
 Assumes pclk at 20 MHz, sub_clk_pin and event pins synchronous-safe
 levels, and zero-wait APB masters.
*/
// Our own choice: the APB slave port.
// Operation
// - Mode bit 7: 0 interval wrap, 1 auto-reload.
// - Mode bits 6:5: 00 up, 01 down, 1x direction pin decides.
// - Direction pin high counts down, low counts up.
// - Mode bit 4 reads as 1, writes ignored.
// - Select x001/x010/x011/x100/0101 give system clock /2048,/512,/64,/16,/4.
// - Select x000 gives system clock divided by 8192.
// - Selects 0110, 1101, 1110 give sub-clock /1024, /256, /4.
// - Select 0111 counts falling event edges, 1111 rising edges.
// - Counter is read-only; reads never disturb counting. A reload write loads it too.
// - Overflow from FF or underflow from 00 sets request flag.
// - Counter reads and reload writes share one address.
// - Reset clears counter to zero.
// - Reload write also loads the counter immediately.
// - Auto-reload loads reload value on overflow or underflow.
// - Reload register is write-only, resets to zero.
// - Enable-one bit 7 enables clock interrupt requests.
// - Enable-two bit 1 enables timer interrupt requests.
// - Mode register resets to 10 hex.
// - Request flag stays set until software writes 0.
`include "timer_defs.svh"

module updown_event_timer_8bit
    import timer_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic sub_clk_pin, // Sub-clock level
    input wire logic event_input_pin, // External event pulses
    input wire logic direction_pin, // High counts down
    output logic timer_irq, // Timer request to processor
    output logic clock_irq_enable // Clock interrupt enable level
);

    mode_ctrl_s mode_r;
    logic [7:0] count_r;
    logic [7:0] reload_r;
    logic clock_irq_en_r;
    logic timer_irq_en_r;
    logic timer_irq_flag_r;
    logic [12:0] sys_presc_r;
    logic [9:0] sub_presc_r;
    logic sub_meta_r;
    logic sub_sync_r;
    logic sub_prev_r;
    logic evt_meta_r;
    logic evt_sync_r;
    logic evt_prev_r;
    logic sub_edge;
    logic evt_rise;
    logic evt_fall;
    logic step;
    logic count_down;
    logic at_limit;
    logic setup_rd;
    logic wr_en;
    logic hit_mode;
    logic hit_count;
    logic hit_en_one;
    logic hit_en_two;
    logic hit_req_two;
    logic mapped;
    logic flag_clear;

    // True when a prescaler value completes a 2^lg division
    function automatic logic div_tick(input logic [12:0] p, input logic [3:0] lg);
        logic [12:0] m;
        m = 13'((14'd1 << lg) - 14'd1);
        return (p & m) == m;
    endfunction : div_tick

    // Register index match on a word-aligned byte address
    function automatic logic addr_hit(input logic [31:0] a, input logic [23:0] idx);
        return (a[31:26] == 6'h00) && (a[25:2] == idx) && (a[1:0] == 2'b00);
    endfunction : addr_hit

    // Address decode
    always_comb
    begin
        hit_mode = 1'b0;
        hit_count = 1'b0;
        hit_en_one = 1'b0;
        hit_en_two = 1'b0;
        hit_req_two = 1'b0;
        if (addr_hit(paddr, `IDX_MODE_CTRL))
            hit_mode = 1'b1;
        else if (addr_hit(paddr, `IDX_COUNT_RELOAD))
            hit_count = 1'b1;
        else if (addr_hit(paddr, `IDX_IRQ_EN_ONE))
            hit_en_one = 1'b1;
        else if (addr_hit(paddr, `IDX_IRQ_EN_TWO))
            hit_en_two = 1'b1;
        else if (addr_hit(paddr, `IDX_IRQ_REQ_TWO))
            hit_req_two = 1'b1;
    end

    // Bus handshake: zero wait states, error on unmapped access
    assign mapped = hit_mode | hit_count | hit_en_one | hit_en_two | hit_req_two;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_en = psel & penable & pwrite & mapped;
    assign flag_clear = wr_en & hit_req_two & ~pwdata[`BIT_TIMER_IRQ_FLAG];

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_rd)
        begin
            prdata <= 32'h0000_0000;
            if (hit_mode)
                prdata[7:0] <= {mode_r[7:5], 1'b1, mode_r[3:0]};
            else if (hit_count)
                prdata[7:0] <= count_r;
            else if (hit_en_one)
                prdata[`BIT_CLOCK_IRQ_EN] <= clock_irq_en_r;
            else if (hit_en_two)
                prdata[`BIT_TIMER_IRQ_EN] <= timer_irq_en_r;
            else if (hit_req_two)
                prdata[`BIT_TIMER_IRQ_FLAG] <= timer_irq_flag_r;
        end
    end

    // Mode control register; bit 4 held at one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= `RST_MODE_CTRL;
        else if (wr_en && hit_mode)
            mode_r <= {pwdata[7:5], 1'b1, pwdata[3:0]};
    end

    // Enable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_irq_en_r <= 1'b0;
            timer_irq_en_r <= 1'b0;
        end
        else
        begin
            if (wr_en && hit_en_one)
                clock_irq_en_r <= pwdata[`BIT_CLOCK_IRQ_EN];
            if (wr_en && hit_en_two)
                timer_irq_en_r <= pwdata[`BIT_TIMER_IRQ_EN];
        end
    end

    // Free-running system and sub-clock prescalers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_presc_r <= 13'h0000;
            sub_presc_r <= 10'h000;
        end
        else
        begin
            sys_presc_r <= sys_presc_r + 13'h0001;
            if (sub_edge)
                sub_presc_r <= sub_presc_r + 10'h001;
        end
    end

    // Two-flop synchronisers with edge history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_meta_r <= 1'b0;
            sub_sync_r <= 1'b0;
            sub_prev_r <= 1'b0;
            evt_meta_r <= 1'b0;
            evt_sync_r <= 1'b0;
            evt_prev_r <= 1'b0;
        end
        else
        begin
            sub_meta_r <= sub_clk_pin;
            sub_sync_r <= sub_meta_r;
            sub_prev_r <= sub_sync_r;
            evt_meta_r <= event_input_pin;
            evt_sync_r <= evt_meta_r;
            evt_prev_r <= evt_sync_r;
        end
    end

    // Edge detection on synchronised levels
    assign sub_edge = sub_sync_r & ~sub_prev_r;
    assign evt_rise = evt_sync_r & ~evt_prev_r;
    assign evt_fall = ~evt_sync_r & evt_prev_r;

    // Count source selection
    always_comb
    begin
        step = 1'b0;
        casez (mode_r.clock_select)
            `CS_SYS_8192: step = div_tick(sys_presc_r, `LG_8192);
            `CS_SYS_2048: step = div_tick(sys_presc_r, `LG_2048);
            `CS_SYS_512: step = div_tick(sys_presc_r, `LG_512);
            `CS_SYS_64: step = div_tick(sys_presc_r, `LG_64);
            `CS_SYS_16: step = div_tick(sys_presc_r, `LG_16);
            `CS_SYS_4: step = div_tick(sys_presc_r, `LG_4);
            `CS_SUB_1024: step = sub_edge & div_tick({3'b000, sub_presc_r}, `LG_1024);
            `CS_SUB_256: step = sub_edge & div_tick({3'b000, sub_presc_r}, `LG_256);
            `CS_SUB_4: step = sub_edge & div_tick({3'b000, sub_presc_r}, `LG_4);
            `CS_EVT_FALL: step = evt_fall;
            `CS_EVT_RISE: step = evt_rise;
            default: step = 1'b0;
        endcase
    end

    // Direction and wrap detection
    assign count_down = mode_r.direction_ctrl_hi ? direction_pin
                                                 : mode_r.direction_ctrl_lo;
    assign at_limit = count_down ? (count_r == 8'h00) : (count_r == 8'hff);

    // Reload register, write-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reload_r <= `RST_RELOAD;
        else if (wr_en && hit_count)
            reload_r <= pwdata[7:0];
    end

    // Counter: a write beats a count step in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= `RST_COUNT;
        else if (wr_en && hit_count)
            count_r <= pwdata[7:0];
        else if (step && at_limit && mode_r.reload_mode_bit)
            count_r <= reload_r;
        else if (step && count_down)
            count_r <= count_r - 8'h01;
        else if (step)
            count_r <= count_r + 8'h01;
    end

    // Request flag: a new wrap wins over a clearing write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_irq_flag_r <= 1'b0;
        else if (step && at_limit && !(wr_en && hit_count))
            timer_irq_flag_r <= 1'b1;
        else if (flag_clear)
            timer_irq_flag_r <= 1'b0;
    end

    // Request and enable outputs
    assign timer_irq = timer_irq_flag_r & timer_irq_en_r;
    assign clock_irq_enable = clock_irq_en_r;

    // Assertions sample on the bus clock and sleep in reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Counter, flag, read and edge checks
    a_wrap_sets_flag: assert property (
        step && at_limit && !(wr_en && hit_count) |=> timer_irq_flag_r)
        else $error("wrap did not set flag");
    a_interval_up_wrap: assert property (
        step && !count_down && count_r == 8'hff && !mode_r.reload_mode_bit
        && !(wr_en && hit_count) |=> count_r == 8'h00)
        else $error("interval wrap wrong");
    a_reload_on_wrap: assert property (
        step && at_limit && mode_r.reload_mode_bit && !(wr_en && hit_count)
        |=> count_r == $past(reload_r))
        else $error("auto-reload failed");
    a_write_loads_both: assert property (
        wr_en && hit_count |=> count_r == $past(pwdata[7:0])
        && reload_r == $past(pwdata[7:0]))
        else $error("reload write not loaded");
    a_hw_dir_down: assert property (
        step && mode_r.direction_ctrl_hi && direction_pin && count_r != 8'h00
        && !(wr_en && hit_count) |=> count_r == $past(count_r) - 8'h01)
        else $error("pin-high did not count down");
    a_flag_sticky: assert property (
        timer_irq_flag_r && !flag_clear |=> timer_irq_flag_r)
        else $error("flag dropped without clear");
    a_rsv_reads_one: assert property (
        setup_rd && hit_mode |=> prdata[`BIT_MODE_RSV])
        else $error("reserved bit read as zero");
    a_irq_gate: assert property (
        timer_irq_flag_r && timer_irq_en_r |-> timer_irq ##1
        (timer_irq || !timer_irq_flag_r || !timer_irq_en_r))
        else $error("request not gated by flag and enable");
    a_event_once: assert property (
        evt_rise |=> !evt_rise)
        else $error("event edge counted twice");
    a_event_fall_once: assert property (
        evt_fall |=> !evt_fall)
        else $error("falling edge counted twice");

    // Direction, counter, flag, read and divider checks
    a_hw_dir_up: assert property (
        step && mode_r.direction_ctrl_hi && !direction_pin && count_r != 8'hff
        && !(wr_en && hit_count) |=> count_r == $past(count_r) + 8'h01)
        else $error("pin-low did not count up");
    a_down_underflow: assert property (
        step && count_down && count_r == 8'h00 && !mode_r.reload_mode_bit
        && !(wr_en && hit_count) |=> count_r == 8'hff)
        else $error("interval underflow wrong");
    a_flag_clears: assert property (
        flag_clear && !(step && at_limit) |=> !timer_irq_flag_r)
        else $error("clearing write left flag set");
    a_count_quiet: assert property (
        !step && !(wr_en && hit_count) |=> count_r == $past(count_r))
        else $error("counter moved without a step");
    a_read_count: assert property (
        setup_rd && hit_count |=> prdata[7:0] == $past(count_r))
        else $error("count read returned wrong value");
    a_sys4_spacing: assert property (
        step && mode_r.clock_select == `CS_SYS_4
        |=> (!step || mode_r.clock_select != `CS_SYS_4) [*3])
        else $error("divide-by-4 steps too close");

    // Main scenarios reached
    c_event_fall: cover property (step && evt_fall);
    c_overflow: cover property (step && !count_down && count_r == 8'hff);
    c_underflow: cover property (step && count_down && count_r == 8'h00);
    c_reload: cover property (step && at_limit && mode_r.reload_mode_bit);
    c_event_count: cover property (step && evt_rise);

endmodule : updown_event_timer_8bit

// File: verif/event_source.sv
/*
 Model of the pulse source on the event pin and of the direction pin.
 Assumes the bench calls its tasks from one process only.
*/
module event_source (
    input wire logic pclk, // System clock
    output logic event_input_pin, // Event pulses, idle low
    output logic direction_pin // High asks for down counting
);
    timeunit 1ns;
    timeprecision 1ns;
    // Both lines start low
    initial
    begin
        event_input_pin = 1'b0;
        direction_pin = 1'b0;
    end
    // Direction level, changed just after an edge
    task set_dir(input logic d);
        @(posedge pclk);
        direction_pin <= d;
    endtask : set_dir
    // Pulses wide enough for the two-flop sampler
    task send(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            event_input_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
    endtask : send
endmodule : event_source

// File: verif/tb_updown_event_timer_8bit.sv
/*
 Self-checking bench of the up/down event timer over APB.
 Assumes the event source model and the register index header.
*/
`include "timer_defs.svh"
module tb_updown_event_timer_8bit;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] A_MODE = {6'h00, `IDX_MODE_CTRL, 2'b00};
    localparam logic [31:0] A_CNT = {6'h00, `IDX_COUNT_RELOAD, 2'b00};
    localparam logic [31:0] A_EN1 = {6'h00, `IDX_IRQ_EN_ONE, 2'b00};
    localparam logic [31:0] A_EN2 = {6'h00, `IDX_IRQ_EN_TWO, 2'b00};
    localparam logic [31:0] A_REQ = {6'h00, `IDX_IRQ_REQ_TWO, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd, rd0, rnd;
    logic event_input_pin, direction_pin, timer_irq, clock_irq_enable;
    logic [2:0] sub_cnt;
    logic [7:0] v;
    int errors, checks_done;
    int per [4] = '{4, 16, 64, 32};
    logic [7:0] code [4] = '{8'h05, 8'h04, 8'h03, 8'h0e};
    updown_event_timer_8bit u_updown_event_timer_8bit (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sub_clk_pin(sub_cnt[2]),
        .event_input_pin(event_input_pin), .direction_pin(direction_pin),
        .timer_irq(timer_irq), .clock_irq_enable(clock_irq_enable));
    event_source u_event_source (.pclk(pclk), .event_input_pin(event_input_pin),
        .direction_pin(direction_pin));
    // Clock and a sub-clock of eight system cycles
    always #25 pclk = ~pclk;
    always @(posedge pclk) sub_cnt <= sub_cnt + 3'd1;
    // Pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Comparison and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // One APB transfer, held until pready is seen high
    task apb(input logic wr, input logic [31:0] a, d, output logic [31:0] r,
             output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
        begin
            errors++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Write, then let the edge's updates land
    task wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, {rnd[31:8], d[7:0]}, rd, err); // Upper bits are ignored
        rnd = lfsr(rnd);
        @(negedge pclk);
    endtask : wr
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
    endtask : rdchk
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge pclk);
        errors++;
        $display("BAD %0t timeout", $time);
        conclude();
    end
    // Main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        sub_cnt = 3'd0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        rnd = 32'hc5e2;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_MODE, 32'h0000_0010);
        rdchk(A_CNT, 32'h0000_0000);
        check(timer_irq, 1'b0);
        wr(A_MODE, 32'h0000_00ef);
        rdchk(A_MODE, 32'h0000_00ff);
        wr(A_MODE, 32'h0000_0000);
        rdchk(A_MODE, 32'h0000_0010);
        apb(1'b0, 32'h0000_0100, 32'h0000_0000, rd, err);
        check(rd, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        wr(A_EN1, 32'h0000_0080);
        check(clock_irq_enable, 1'b1);
        rdchk(A_EN1, 32'h0000_0080);
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(A_MODE, {24'h0, code[i]});
            apb(1'b0, A_CNT, 32'h0000_0000, rd0, err);
            repeat (10 * per[i] - 3) @(posedge pclk);
            rdchk(A_CNT, {24'h0, rd0[7:0] + 8'd10});
        end
        $display("test clock sources done");
        // Interval overflow and auto-reload, counted on rising event edges
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'hff : (8'hfc | rnd[1:0]);
            rnd = lfsr(rnd);
            wr(A_MODE, i[0] ? 32'h0000_008f : 32'h0000_000f);
            wr(A_CNT, {24'h0, v});
            rdchk(A_CNT, {24'h0, v});
            wr(A_REQ, 32'h0000_0000);
            u_event_source.send(255 - v);
            rdchk(A_REQ, 32'h0000_0000);
            u_event_source.send(1);
            rdchk(A_CNT, i[0] ? {24'h0, v} : 32'h0000_0000);
            apb(1'b0, A_REQ, 32'h0000_0000, rd, err);
            check(rd[1], 1'b1);
        end
        check(timer_irq, 1'b0);
        wr(A_EN2, 32'h0000_0002);
        check(timer_irq, 1'b1);
        rdchk(A_EN2, 32'h0000_0002);
        wr(A_REQ, 32'h0000_0002);
        check(timer_irq, 1'b1);
        wr(A_REQ, 32'h0000_0000);
        check(timer_irq, 1'b0);
        $display("test overflow and reload done");
        wr(A_MODE, 32'h0000_002f);
        wr(A_CNT, 32'h0000_0001);
        u_event_source.send(2);
        rdchk(A_CNT, 32'h0000_00ff);
        check(timer_irq, 1'b1);
        wr(A_MODE, 32'h0000_004f);
        u_event_source.set_dir(1'b1);
        wr(A_CNT, 32'h0000_0005);
        u_event_source.send(2);
        rdchk(A_CNT, 32'h0000_0003);
        wr(A_MODE, 32'h0000_006f);
        u_event_source.set_dir(1'b0);
        u_event_source.send(1);
        rdchk(A_CNT, 32'h0000_0004);
        wr(A_MODE, 32'h0000_0007);
        wr(A_CNT, 32'h0000_0000);
        v = {5'h00, rnd[2:0]} + 8'd1;
        u_event_source.send(v);
        rdchk(A_CNT, {24'h0, v});
        $display("test direction and edges done");
        // Reset in mid-run: reload must return to zero as well
        wr(A_CNT, 32'h0000_005a);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check(timer_irq, 1'b0);
        check(clock_irq_enable, 1'b0);
        rdchk(A_MODE, 32'h0000_0010);
        rdchk(A_CNT, 32'h0000_0000);
        wr(A_MODE, 32'h0000_00af);
        u_event_source.send(1);
        rdchk(A_CNT, 32'h0000_0000);
        apb(1'b0, A_REQ, 32'h0000_0000, rd, err);
        check(rd[1], 1'b1);
        $display("test reset in run done");
        conclude();
    end
endmodule : tb_updown_event_timer_8bit
